//--- rtl/acr_pkg.sv
// Package of constants and types for the converter configuration bank
package acr_pkg;
    // ========================================================
    // Register indices (byte address is four times the index)
    localparam logic [2:0] IDX_RATE_MODE = 3'h1; // Rate and mode
    localparam logic [2:0] IDX_REF_CUR   = 3'h2; // Reference, filter, current
    localparam logic [2:0] IDX_ROUTE_RDY = 3'h3; // Routing and ready mode
    localparam logic [2:0] IDX_COMMAND   = 3'h4; // Command strobes
    localparam logic [2:0] IDX_CLOCK     = 3'h5; // External clock setup
    localparam logic [2:0] IDX_STATUS    = 3'h6; // Decoded state
    // ========================================================
    // Reset values
    localparam logic [7:0]  RESET_CFG   = 8'h00;
    localparam logic [15:0] REF_CLK_KHZ = 16'h1000; // 4096 kHz
    localparam int          SCALE_SHIFT = 12;       // Divide by 4096
    // ========================================================
    // Field positions
    localparam int RATE_MSB = 7, RATE_LSB = 5;
    localparam int MODE_MSB = 4, MODE_LSB = 3;
    localparam int REF_MSB = 7, REF_LSB = 6;
    localparam int FILT_MSB = 5, FILT_LSB = 4;
    localparam int SWITCH_BIT = 3;
    localparam int CUR_MSB = 2, CUR_LSB = 0;
    localparam int SRC1_MSB = 7, SRC1_LSB = 5;
    localparam int SRC2_MSB = 4, SRC2_LSB = 2;
    localparam int READY_MODE_BIT = 1;
    localparam int CMD_START_BIT = 0, CMD_SLEEP_BIT = 1;
    localparam int CLK_EXT_BIT = 16;
    localparam int ST_VALID_BIT = 17, ST_SWITCH_BIT = 18;
    // ========================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_DUTY   = 2'h1,
        MODE_TURBO  = 2'h2,
        MODE_UNUSED = 2'h3
    } acr_mode_type;
    // Rates in quarter samples per second, codes 0 to 6
    localparam logic [12:0] NORMAL_RATE_Q [0:6] = '{13'h0050, 13'h00B4,
        13'h0168, 13'h02BC, 13'h0528, 13'h0960, 13'h0FA0};
    localparam logic [12:0] DUTY_RATE_Q [0:6] = '{13'h0014, 13'h002D,
        13'h005A, 13'h00B0, 13'h014A, 13'h0258, 13'h03E8};
    localparam logic [12:0] TURBO_RATE_Q [0:6] = '{13'h00A0, 13'h0168,
        13'h02D0, 13'h0578, 13'h0A50, 13'h12C0, 13'h1F40};
    // Excitation current in microamperes, codes 2 to 7
    localparam logic [10:0] CURRENT_UA [2:7] = '{11'h0032, 11'h0064,
        11'h00FA, 11'h01F4, 11'h03E8, 11'h05DC};
    localparam logic [2:0] CODE_UNUSED = 3'h7;
endpackage : acr_pkg

//--- rtl/acr_dec_if.sv
// Interface between the bank and its two decoders
`timescale 1ns/1ns
interface acr_dec_if;
    logic [7:0]  rate_mode;   // Rate and mode register
    logic [7:0]  ref_cur;     // Reference and current register
    logic [7:0]  route_rdy;   // Routing register
    logic        clk_ext;     // External clock in use
    logic [15:0] clk_khz;     // External clock frequency
    logic [16:0] rate_q;      // Scaled rate, quarter SPS
    logic        rate_valid;  // Mode and code are usable
    logic [1:0]  line_filter; // Effective filter choice
    logic [10:0] current_ua;  // Current magnitude
    logic [5:0]  src1_pins;   // Source one pin select
    logic [5:0]  src2_pins;   // Source two pin select
    modport bank_mp (output rate_mode, ref_cur, route_rdy, clk_ext,
        clk_khz, input rate_q, rate_valid, line_filter, current_ua,
        src1_pins, src2_pins);
    modport rate_mp (input rate_mode, ref_cur, clk_ext, clk_khz,
        output rate_q, rate_valid, line_filter);
    modport drive_mp (input ref_cur, route_rdy,
        output current_ua, src1_pins, src2_pins);
endinterface : acr_dec_if

//--- rtl/acr_rate_decode.sv
// Rate and line filter decoder
`timescale 1ns/1ns
module acr_rate_decode
    import acr_pkg::*;
(
    acr_dec_if.rate_mp dec
);
    // ========================================================
    // Rate decode and clock scaling
    logic [2:0]   code;     // Rate code
    acr_mode_type mode;     // Operating mode
    logic [12:0]  base_q;   // Unscaled rate
    logic [28:0]  product;  // Rate times clock

    always_comb begin
        code   = dec.rate_mode[RATE_MSB:RATE_LSB];
        mode   = acr_mode_type'(dec.rate_mode[MODE_MSB:MODE_LSB]);
        base_q = 13'h0000;
        dec.rate_valid = (code != CODE_UNUSED);
        unique case (mode)
            MODE_NORMAL: begin
                if (dec.rate_valid) base_q = NORMAL_RATE_Q[code];
            end
            MODE_DUTY: begin
                if (dec.rate_valid) base_q = DUTY_RATE_Q[code];
            end
            MODE_TURBO: begin
                if (dec.rate_valid) base_q = TURBO_RATE_Q[code];
            end
            MODE_UNUSED: begin
                dec.rate_valid = 1'b0;
            end
        endcase
        // Rate follows the external clock in proportion
        product = 29'(base_q) * 29'(dec.clk_khz);
        if (dec.clk_ext)
            dec.rate_q = product[SCALE_SHIFT +: 17];
        else
            dec.rate_q = 17'(base_q);
        // Filter choice acts only at the slowest normal and duty rates
        if (code == 3'h0 && (mode == MODE_NORMAL || mode == MODE_DUTY))
            dec.line_filter = dec.ref_cur[FILT_MSB:FILT_LSB];
        else
            dec.line_filter = 2'h0;
    end
endmodule : acr_rate_decode

//--- rtl/acr_drive_decode.sv
// Excitation current and routing decoder
`timescale 1ns/1ns
module acr_drive_decode
    import acr_pkg::*;
(
    acr_dec_if.drive_mp dec
);
    // ========================================================
    // Routing code to one-hot pin select, unused codes give none
    function automatic logic [5:0] route_pins(input logic [2:0] c);
        if (c == 3'h0 || c == CODE_UNUSED)
            return 6'h00;
        return 6'h01 << (c - 3'h1);
    endfunction : route_pins

    logic [2:0] cur_code; // Current magnitude code

    // Shared magnitude and per-source routing
    always_comb begin
        cur_code = dec.ref_cur[CUR_MSB:CUR_LSB];
        if (cur_code < 3'h2)
            dec.current_ua = 11'h000;
        else
            dec.current_ua = CURRENT_UA[cur_code];
        dec.src1_pins = route_pins(dec.route_rdy[SRC1_MSB:SRC1_LSB]);
        dec.src2_pins = route_pins(dec.route_rdy[SRC2_MSB:SRC2_LSB]);
    end
endmodule : acr_drive_decode

//--- rtl/acr_config_bank.sv
// Configuration register bank with Wishbone slave
// Overview of operation
// - Rate code decodes per mode; code seven unused
// - External clock scales rate proportionally
// - Bits 7:6 pick conversion reference
// - Bits 5:4 pick line filter coefficients
// - Filter choice acts only at slowest normal and duty rates
// - Switch closes on start, opens on sleep
// - Bits 2:0 set shared excitation magnitude
// - Bits 7:5 route excitation source one
// - Bits 4:2 route source two identically
// - Ready mode adds shared pin indication
// - Rate field sits at bits 7:5
// - Mode field selects normal, duty, turbo
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module acr_config_bank
    import acr_pkg::*;
#(
    parameter int ADR_W = 8 // Byte address width
)(
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire logic               CYC_I,
    input  wire logic               STB_I,
    input  wire logic               WE_I,
    input  wire logic [ADR_W-1:0]   ADR_I,
    input  wire logic [3:0]         SEL_I,
    input  wire logic [31:0]        DAT_I,
    output      logic [31:0]        DAT_O,
    output      logic               ACK_O,
    input  wire logic               DATA_READY,
    output      logic [16:0]        RATE_QSPS,
    output      logic               RATE_VALID,
    output      logic [1:0]         REF_SELECT,
    output      logic [1:0]         LINE_FILTER,
    output      logic               LOW_SIDE_SWITCH_CLOSED,
    output      logic [10:0]        EXCITATION_CURRENT_LEVEL,
    output      logic [5:0]         SOURCE_ONE_ROUTING,
    output      logic [5:0]         SOURCE_TWO_ROUTING,
    output      logic               DEDICATED_READY_PIN,
    output      logic               SHARED_DATAOUT_READY_PIN
);
    import acr_pkg::*;

    // ========================================================
    // Bus handshake state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } acr_bus_type;

    acr_bus_type bus_state, next_bus_state; // Ack state
    logic [31:0] dat, next_dat;             // Read data
    logic        request;                   // New access seen
    logic        commit;                    // Access completes
    logic [2:0]  index;                     // Register index
    logic        mapped;                    // Address decodes

    // Decode the word index, upper bits must be zero
    always_comb begin
        index  = ADR_I[4:2];
        mapped = (ADR_I[ADR_W-1:5] == '0) && (ADR_I[1:0] == 2'h0) &&
                 (index >= IDX_RATE_MODE) && (index <= IDX_STATUS);
    end

    // ========================================================
    // Configuration storage
    logic [7:0]  rate_mode, next_rate_mode; // Rate and mode
    logic [7:0]  ref_cur, next_ref_cur;     // Reference etc
    logic [7:0]  route_rdy, next_route_rdy; // Routing etc
    logic [16:0] clk_cfg, next_clk_cfg;     // Ext enable and kHz
    logic        cmd_start, next_cmd_start; // Start pulse
    logic        cmd_sleep, next_cmd_sleep; // Sleep pulse

    // Merge one written byte lane
    function automatic logic [7:0] lane(input logic [7:0] old,
                                        input int n);
        return SEL_I[n] ? DAT_I[8*n +: 8] : old;
    endfunction : lane

    // Read multiplexer; unmapped and command read zero
    function automatic logic [31:0] read_word(input logic [2:0] i);
        unique case (i)
            IDX_RATE_MODE: return {24'h00_0000, rate_mode};
            IDX_REF_CUR:   return {24'h00_0000, ref_cur};
            IDX_ROUTE_RDY: return {24'h00_0000, route_rdy};
            IDX_CLOCK:     return {15'h0000, clk_cfg};
            IDX_STATUS:    return {13'h0000, LOW_SIDE_SWITCH_CLOSED,
                                   RATE_VALID, RATE_QSPS};
            default:       return 32'h0000_0000;
        endcase
    endfunction : read_word

    // Bus and register next values
    always_comb begin
        request        = CYC_I && STB_I && (bus_state == BUS_IDLE);
        commit         = CYC_I && STB_I && (bus_state == BUS_ACK);
        next_bus_state = request ? BUS_ACK : BUS_IDLE;
        next_dat       = request && mapped ? read_word(index)
                                           : 32'h0000_0000;
        next_rate_mode = rate_mode;
        next_ref_cur   = ref_cur;
        next_route_rdy = route_rdy;
        next_clk_cfg   = clk_cfg;
        next_cmd_start = 1'b0;
        next_cmd_sleep = 1'b0;
        // Writes take effect at the edge that ends the ack cycle
        if (commit && WE_I && mapped) begin
            unique case (index)
                IDX_RATE_MODE: begin
                    next_rate_mode = lane(rate_mode, 0);
                end
                IDX_REF_CUR: begin
                    next_ref_cur = lane(ref_cur, 0);
                end
                IDX_ROUTE_RDY: begin
                    // Reserved bit stored as written
                    next_route_rdy = lane(route_rdy, 0);
                end
                IDX_COMMAND: begin
                    if (SEL_I[0]) begin
                        next_cmd_start = DAT_I[CMD_START_BIT];
                        next_cmd_sleep = DAT_I[CMD_SLEEP_BIT];
                    end
                end
                IDX_CLOCK: begin
                    next_clk_cfg[7:0]  = lane(clk_cfg[7:0], 0);
                    next_clk_cfg[15:8] = lane(clk_cfg[15:8], 1);
                    if (SEL_I[2])
                        next_clk_cfg[CLK_EXT_BIT] = DAT_I[CLK_EXT_BIT];
                end
                default: begin
                    // Status is read only
                end
            endcase
        end
    end

    // Register bus and configuration state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_state <= BUS_IDLE;
            dat       <= 32'h0000_0000;
            rate_mode <= RESET_CFG;
            ref_cur   <= RESET_CFG;
            route_rdy <= RESET_CFG;
            clk_cfg   <= {1'b0, REF_CLK_KHZ};
            cmd_start <= 1'b0;
            cmd_sleep <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            dat       <= next_dat;
            rate_mode <= next_rate_mode;
            ref_cur   <= next_ref_cur;
            route_rdy <= next_route_rdy;
            clk_cfg   <= next_clk_cfg;
            cmd_start <= next_cmd_start;
            cmd_sleep <= next_cmd_sleep;
        end
    end

    assign ACK_O = bus_state[1];
    assign DAT_O = dat;

    // ========================================================
    // Decoders
    acr_dec_if dec ();

    assign dec.rate_mode = rate_mode;
    assign dec.ref_cur   = ref_cur;
    assign dec.route_rdy = route_rdy;
    assign dec.clk_ext   = clk_cfg[CLK_EXT_BIT];
    assign dec.clk_khz   = clk_cfg[15:0];

    acr_rate_decode i_acr_rate_decode (
        .dec (dec.rate_mp)
    );

    acr_drive_decode i_acr_drive_decode (
        .dec (dec.drive_mp)
    );

    // ========================================================
    // Registered outputs
    logic [16:0] next_rate_q;   // Scaled rate
    logic        next_valid;    // Rate usable
    logic [1:0]  next_ref;      // Reference select
    logic [1:0]  next_filter;   // Filter select
    logic        next_switch;   // Switch state
    logic [10:0] next_current;  // Current level
    logic [5:0]  next_src1;     // Source one pins
    logic [5:0]  next_src2;     // Source two pins
    logic        next_ded_rdy;  // Dedicated ready
    logic        next_shr_rdy;  // Shared ready

    // Output next values
    always_comb begin
        next_rate_q  = dec.rate_q;
        next_valid   = dec.rate_valid;
        next_ref     = ref_cur[REF_MSB:REF_LSB];
        next_filter  = dec.line_filter;
        next_current = dec.current_ua;
        next_src1    = dec.src1_pins;
        next_src2    = dec.src2_pins;
        // Sleep wins if both commands arrive together
        next_switch  = LOW_SIDE_SWITCH_CLOSED;
        if (!ref_cur[SWITCH_BIT] || cmd_sleep)
            next_switch = 1'b0;
        else if (cmd_start)
            next_switch = 1'b1;
        next_ded_rdy = DATA_READY;
        next_shr_rdy = DATA_READY && route_rdy[READY_MODE_BIT];
    end

    // Output registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RATE_QSPS                <= '0;
            RATE_VALID               <= 1'b0;
            REF_SELECT               <= 2'h0;
            LINE_FILTER              <= 2'h0;
            LOW_SIDE_SWITCH_CLOSED   <= 1'b0;
            EXCITATION_CURRENT_LEVEL <= 11'h000;
            SOURCE_ONE_ROUTING       <= 6'h00;
            SOURCE_TWO_ROUTING       <= 6'h00;
            DEDICATED_READY_PIN      <= 1'b0;
            SHARED_DATAOUT_READY_PIN <= 1'b0;
        end else begin
            RATE_QSPS                <= next_rate_q;
            RATE_VALID               <= next_valid;
            REF_SELECT               <= next_ref;
            LINE_FILTER              <= next_filter;
            LOW_SIDE_SWITCH_CLOSED   <= next_switch;
            EXCITATION_CURRENT_LEVEL <= next_current;
            SOURCE_ONE_ROUTING       <= next_src1;
            SOURCE_TWO_ROUTING       <= next_src2;
            DEDICATED_READY_PIN      <= next_ded_rdy;
            SHARED_DATAOUT_READY_PIN <= next_shr_rdy;
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // Base case: normal mode, code zero, internal clock
    logic norm_zero; // Slowest normal rate selected
    assign norm_zero = rate_mode[7:3] == 5'h00;

    rate_table_a: assert property (norm_zero && !clk_cfg[CLK_EXT_BIT]
        |=> RATE_QSPS == 17'(NORMAL_RATE_Q[0]) && RATE_VALID)
        else $error("normal rate code zero wrong");
    rate_scale_a: assert property (norm_zero && clk_cfg[CLK_EXT_BIT] &&
        clk_cfg[15:0] == 16'h2000 |=> RATE_QSPS == 17'h0_00A0)
        else $error("rate not scaled by clock");
    turbo_mode_a: assert property (rate_mode[7:3] == 5'h02 &&
        !clk_cfg[CLK_EXT_BIT] |=> RATE_QSPS == 17'(TURBO_RATE_Q[0]))
        else $error("turbo rate wrong");
    ref_follow_a: assert property (##1 REF_SELECT ==
        $past(ref_cur[REF_MSB:REF_LSB]))
        else $error("reference select wrong");
    filter_pass_a: assert property (norm_zero |=> LINE_FILTER ==
        $past(ref_cur[FILT_MSB:FILT_LSB]))
        else $error("filter choice not applied");
    filter_gate_a: assert property (rate_mode[RATE_MSB:RATE_LSB] != 3'h0
        |=> LINE_FILTER == 2'h0)
        else $error("filter applied at fast rate");
    switch_open_a: assert property (!ref_cur[SWITCH_BIT]
        |=> !LOW_SIDE_SWITCH_CLOSED)
        else $error("switch closed while disabled");
    switch_close_a: assert property (ref_cur[SWITCH_BIT] && cmd_start &&
        !cmd_sleep |=> LOW_SIDE_SWITCH_CLOSED)
        else $error("switch did not close on start");
    current_top_a: assert property (ref_cur[CUR_MSB:CUR_LSB] == 3'h7
        |=> EXCITATION_CURRENT_LEVEL == CURRENT_UA[7])
        else $error("top current wrong");
    route_one_a: assert property (route_rdy[SRC1_MSB:SRC1_LSB] == 3'h1
        |=> SOURCE_ONE_ROUTING == 6'h01)
        else $error("source one routing wrong");
    route_two_a: assert property (route_rdy[SRC2_MSB:SRC2_LSB] ==
        CODE_UNUSED |=> SOURCE_TWO_ROUTING == 6'h00)
        else $error("unused routing drove a pin");
    ready_mode_a: assert property (!route_rdy[READY_MODE_BIT]
        |=> !SHARED_DATAOUT_READY_PIN)
        else $error("shared ready while disabled");
    unused_rate_a: assert property (rate_mode[RATE_MSB:RATE_LSB] ==
        CODE_UNUSED |=> !RATE_VALID && RATE_QSPS == '0)
        else $error("unused rate decoded");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");

    write_c: cover property (commit && WE_I && mapped);
    close_c: cover property (!LOW_SIDE_SWITCH_CLOSED
        ##1 LOW_SIDE_SWITCH_CLOSED);
    shared_c: cover property (SHARED_DATAOUT_READY_PIN);
    scaled_c: cover property (clk_cfg[CLK_EXT_BIT] && RATE_VALID);
endmodule : acr_config_bank

//--- dv/acr_host_model.sv
// Host model: Wishbone master that configures the bank
`timescale 1ns/1ns
module acr_host_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdata,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      wdata
);
    // ========================================================
    // Bus idle at time zero
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdata = 32'h0000_0000;
    end
    // One classic cycle, held until ack; gives up after 50 edges
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output bit ok);
        logic [31:0] dd;
        int          i;
        dd = d;
        if (w && a == 8'h0C) begin
            dd[0] = 1'b0;
        end
        ok = 1'b0;
        q = 32'h0000_0000;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdata <= dd;
        for (i = 0; i < 50 && !ok; i++) begin
            @(posedge clk);
            ok = (ack === 1'b1);
            q = rdata;
        end
        // Released lines stop showing the old value
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        adr <= ~a;
        wdata <= ~dd;
    endtask : xfer
endmodule : acr_host_model

//--- dv/adc_config_register_bank_bench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module adc_config_register_bank_bench;
    logic clk = 1'b0, reset = 1'b1, data_ready = 1'b0;
    logic cyc, stb, we, ack, valid, sw, ded, shr;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdata, rdata, q;
    logic [16:0] rate;
    logic [1:0]  refs, filt;
    logic [10:0] cur;
    logic [5:0]  src1, src2;
    int num_errors = 0, n_checks = 0;
    // Rates in quarter SPS per mode and code
    int rtab [0:2][0:6] = '{'{80, 180, 360, 700, 1320, 2400, 4000},
        '{20, 45, 90, 176, 330, 600, 1000},
        '{160, 360, 720, 1400, 2640, 4800, 8000}};
    int ctab [0:7] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
    // ========================================================
    // Clock, devices
    always #10 clk = ~clk;
    acr_host_model i_acr_host_model (.clk(clk), .ack(ack), .rdata(rdata),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdata(wdata));
    acr_config_bank i_acr_config_bank (.CLK(clk), .RESET(reset),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(wdata), .DAT_O(rdata), .ACK_O(ack), .DATA_READY(data_ready),
        .RATE_QSPS(rate), .RATE_VALID(valid), .REF_SELECT(refs),
        .LINE_FILTER(filt), .LOW_SIDE_SWITCH_CLOSED(sw),
        .EXCITATION_CURRENT_LEVEL(cur), .SOURCE_ONE_ROUTING(src1),
        .SOURCE_TWO_ROUTING(src2), .DEDICATED_READY_PIN(ded),
        .SHARED_DATAOUT_READY_PIN(shr));
    // ========================================================
    // Verdict and bus helpers
    task automatic final_report();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        bit ok;
        i_acr_host_model.xfer(w, a, d, q, ok);
        if (!ok) begin
            num_errors++;
            final_report();
        end
        // Decoded outputs land one edge after the ack edge
        repeat (3) @(posedge clk);
        #1;
    endtask : acc
    // ========================================================
    // Scenarios
    task automatic t_reset();
        acc(0, 8'h08, 0);
        `CHK("cfg2", 0, q)
        acc(0, 8'h0C, 0);
        `CHK("cfg3", 0, q)
        `CHK("rate", 80, rate)
    endtask : t_reset
    task automatic t_rate();
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 8; c++) begin
                acc(1, 8'h04, {c[2:0], m[1:0], 3'b000});
                `CHK("rate", (m < 3 && c < 7) ? rtab[m][c] : 0, rate)
                `CHK("valid", (m < 3 && c < 7), valid)
                acc(0, 8'h04, 0);
                `CHK("rbk", {c[2:0], m[1:0], 3'b000}, q)
            end
        end
    endtask : t_rate
    task automatic t_clock();
        acc(1, 8'h04, 0);
        acc(1, 8'h14, 32'h0001_0800);
        `CHK("rate2048", 40, rate)
        acc(1, 8'h14, 32'h0001_1800);
        `CHK("rate6144", 120, rate)
        acc(1, 8'h14, 32'h0001_2000);
        `CHK("rate8192", 160, rate)
        acc(0, 8'h14, 0);
        `CHK("clkreg", 32'h0001_2000, q)
        acc(0, 8'h18, 0);
        `CHK("status", 32'h0002_00A0, q)
        acc(1, 8'h14, 32'h0000_1000);
    endtask : t_clock
    task automatic t_cfg2();
        for (int v = 0; v < 4; v++) begin
            acc(1, 8'h08, {v[1:0], v[1:0], 4'h0});
            `CHK("ref", v, refs)
            `CHK("filt", v, filt)
        end
        acc(1, 8'h04, 8'h20);
        `CHK("filt n1", 0, filt)
        acc(1, 8'h04, 8'h08);
        `CHK("filt d0", 3, filt)
        acc(1, 8'h04, 8'h28);
        `CHK("filt d1", 0, filt)
        acc(1, 8'h04, 8'h10);
        `CHK("filt t0", 0, filt)
        for (int c = 0; c < 8; c++) begin
            acc(1, 8'h08, c);
            `CHK("cur", ctab[c], cur)
        end
    endtask : t_cfg2
    task automatic t_route();
        int e1, e2;
        for (int c = 0; c < 8; c++) begin
            acc(1, 8'h0C, {c[2:0], 3'(7 - c), 2'b00});
            e1 = (c > 0 && c < 7) ? (1 << (c - 1)) : 0;
            e2 = (c > 0 && c < 7) ? (1 << (6 - c)) : 0;
            `CHK("src1", e1, src1)
            `CHK("src2", e2, src2)
            acc(0, 8'h0C, 0);
            `CHK("cfg3", {c[2:0], 3'(7 - c), 2'b00}, q)
        end
    endtask : t_route
    task automatic t_switch();
        acc(1, 8'h08, 0);
        acc(1, 8'h10, 1);
        `CHK("sw off", 0, sw)
        acc(1, 8'h08, 8'h08);
        `CHK("sw arm", 0, sw)
        acc(1, 8'h10, 1);
        `CHK("sw start", 1, sw)
        acc(1, 8'h10, 2);
        `CHK("sw sleep", 0, sw)
    endtask : t_switch
    task automatic t_ready();
        for (int m = 0; m < 2; m++) begin
            acc(1, 8'h0C, {6'h00, m[0], 1'b0});
            @(posedge clk);
            data_ready <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            `CHK("ded", 1, ded)
            `CHK("shr", m, shr)
            @(posedge clk);
            data_ready <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            `CHK("ded low", 0, ded)
            `CHK("shr low", 0, shr)
        end
        acc(0, 8'h00, 0);
        `CHK("unmapped", 0, q)
    endtask : t_ready
    // ========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_rate();
        t_clock();
        t_cfg2();
        t_route();
        t_switch();
        t_ready();
        final_report();
    end
endmodule : adc_config_register_bank_bench
